// *** rtl/tap_port_pkg.sv ***
/*
 * Shared types and constants for the test access and debug event port.
 * Assumes a single system clock; every pin is asynchronous to it.
 */
package tap_port_pkg;

	// ==========================================================
	// Timing
	localparam int SYS_CLK_PERIOD_NS = 50;
	localparam int DBG_PULSE_NS      = 100;
	// Least time, rounded up, never below one cycle
	localparam int DBG_PULSE_CYCLES  =
		((DBG_PULSE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS) < 1 ? 1 :
		((DBG_PULSE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);

	// ==========================================================
	// Instruction register
	localparam int           IR_WIDTH     = 4;
	localparam logic [3:0]   IR_CAPTURE   = 4'h1;
	localparam logic [3:0]   IR_RESET_VAL = 4'hF;
	localparam logic [3:0]   INSN_BYPASS  = 4'hF;
	localparam logic [3:0]   INSN_STREAM  = 4'h1;

	// ==========================================================
	// Stream data path
	localparam int WORD_WIDTH = 8;
	localparam int FIFO_DEPTH = 4;

	// ==========================================================
	// Controller states
	typedef enum logic [3:0] {
		TLR    = 4'h0, RTI    = 4'h1, SELDR  = 4'h2, CAPDR  = 4'h3,
		SHDR   = 4'h4, EX1DR  = 4'h5, PSDR   = 4'h6, EX2DR  = 4'h7,
		UPDR   = 4'h8, SELIR  = 4'h9, CAPIR  = 4'hA, SHIR   = 4'hB,
		EX1IR  = 4'hC, PSIR   = 4'hD, EX2IR  = 4'hE, UPIR   = 4'hF
	} tap_state_t;

	// ==========================================================
	// Pin group from the host
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic trstIn;
	} jtag_pins_t;

endpackage : tap_port_pkg

// *** rtl/test_access_debug_port.sv ***
/*
 * Test access port controller, serial shift path, stream receive FIFO
 * and debug event output on the shared test reset pin.
 * Assumes the host drives the test clock well below the system clock
 * (a test clock period of at least eight system clocks) and that a
 * board-level resolver forms pin levels from the output enables.
 */
// Behaviour
// [R1] Logic follows the gated host test clock
// [R2] Mode select sampled on rising edges
// [R3] Data input captured on rising edges
// [R4] Output driven only in shift states
// [R5] Output changes only on falling edges
// [R6] Low test reset resets the controller
// [R7] Low pulse on each debug event
// [R8] Shared pin as output ignores reset
// [R9] Host asserts test reset with system reset
// [R10] Host may reset processor alone
// [R11] Standard sixteen-state controller sequence
`timescale 1ns/1ns

module stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_reg;
	logic [AW-1:0]    rdPtr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	assign inReady  = (count_reg != (AW+1)'(DEPTH));
	assign outValid = (count_reg != '0);
	assign outData  = mem[rdPtr_reg];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_reg] <= inData;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
			end
			if (pop) begin
				rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : stream_fifo

module test_access_debug_port #(
	parameter int WORD_W = tap_port_pkg::WORD_WIDTH,
	parameter int DEPTH  = tap_port_pkg::FIFO_DEPTH
) (
	input  wire logic                    sys_clk,
	input  wire logic                    rst_n,
	input  wire tap_port_pkg::jtag_pins_t pins,
	output logic                         tdoOut,
	output logic                         tdoOe_n,
	output logic                         debugEventOut_n,
	output logic                         debugPinOe_n,
	input  wire logic                    debugOutEnable,
	input  wire logic                    debugEvent,
	output logic [3:0]                   tapState,
	output logic [WORD_W-1:0]            streamData,
	output logic                         streamValid,
	input  wire logic                    streamTake,
	output logic                         streamReady
);
	import tap_port_pkg::*;

	// ==========================================================
	// Pin synchronisers
	logic [3:0] pinMeta_reg;
	logic [3:0] pinSync_reg;
	logic       tckLast_reg;
	logic       tckRise;
	logic       tckFall;
	logic       tmsS;
	logic       tdiS;
	logic       trstS_n;
	logic [2:0] enHold_reg;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pinMeta_reg <= 4'h7;
			pinSync_reg <= 4'h7;
			tckLast_reg <= 1'b0;
			enHold_reg  <= 3'h0;
		end else begin
			pinMeta_reg <= pins;
			pinSync_reg <= pinMeta_reg;
			tckLast_reg <= pinSync_reg[3];
			enHold_reg  <= {enHold_reg[1:0], debugOutEnable};
		end
	end

	// [R1] Edges of the gated clock
	assign tckRise = pinSync_reg[3] && !tckLast_reg;
	assign tckFall = !pinSync_reg[3] && tckLast_reg;
	assign tmsS    = pinSync_reg[2];
	assign tdiS    = pinSync_reg[1];
	// [R8] Masked while driving and until the pin settles
	assign trstS_n = pinSync_reg[0] || debugOutEnable || (|enHold_reg);

	// ==========================================================
	// Controller
	tap_state_t state_reg;
	tap_state_t state_next;

	// [R11] Standard state sequence
	always_comb begin
		case (state_reg)
			TLR:     state_next = tmsS ? TLR   : RTI;
			RTI:     state_next = tmsS ? SELDR : RTI;
			SELDR:   state_next = tmsS ? SELIR : CAPDR;
			CAPDR:   state_next = tmsS ? EX1DR : SHDR;
			SHDR:    state_next = tmsS ? EX1DR : SHDR;
			EX1DR:   state_next = tmsS ? UPDR  : PSDR;
			PSDR:    state_next = tmsS ? EX2DR : PSDR;
			EX2DR:   state_next = tmsS ? UPDR  : SHDR;
			UPDR:    state_next = tmsS ? SELDR : RTI;
			SELIR:   state_next = tmsS ? TLR   : CAPIR;
			CAPIR:   state_next = tmsS ? EX1IR : SHIR;
			SHIR:    state_next = tmsS ? EX1IR : SHIR;
			EX1IR:   state_next = tmsS ? UPIR  : PSIR;
			PSIR:    state_next = tmsS ? EX2IR : PSIR;
			EX2IR:   state_next = tmsS ? UPIR  : SHIR;
			UPIR:    state_next = tmsS ? SELDR : RTI;
			default: state_next = TLR;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= TLR;
		// [R6] Test reset forces reset state
		end else if (!trstS_n) begin
			state_reg <= TLR;
		// [R2] Advance on rising edge
		end else if (tckRise) begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tapState <= 4'h0;
		end else begin
			tapState <= state_reg;
		end
	end

	// ==========================================================
	// Instruction and data shift registers
	logic [IR_WIDTH-1:0] irShift_reg;
	logic [IR_WIDTH-1:0] ir_reg;
	logic [WORD_W-1:0]   drShift_reg;
	logic                bypass_reg;
	logic [$clog2(WORD_W+1)-1:0] bitCnt_reg;
	logic                wordDone;
	logic                fifoInReady;

	assign wordDone = tckRise && state_reg == SHDR && ir_reg == INSN_STREAM
		&& bitCnt_reg == ($clog2(WORD_W+1))'(WORD_W - 1);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irShift_reg <= '0;
			ir_reg      <= IR_RESET_VAL;
		end else if (!trstS_n || (tckRise && state_reg == TLR)) begin
			ir_reg      <= IR_RESET_VAL;
		end else if (tckRise) begin
			case (state_reg)
				CAPIR:   irShift_reg <= IR_CAPTURE;
				// [R3] Data bit taken on rise
				SHIR:    irShift_reg <= {tdiS, irShift_reg[IR_WIDTH-1:1]};
				UPIR:    ir_reg      <= irShift_reg;
				default: irShift_reg <= irShift_reg;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			drShift_reg <= '0;
			bypass_reg  <= 1'b0;
			bitCnt_reg  <= '0;
		end else if (tckRise) begin
			case (state_reg)
				CAPDR: begin
					drShift_reg <= '0;
					bypass_reg  <= 1'b0;
					bitCnt_reg  <= '0;
				end
				// [R3] Stream bits taken on rise
				SHDR: begin
					drShift_reg <= {tdiS, drShift_reg[WORD_W-1:1]};
					bypass_reg  <= tdiS;
					bitCnt_reg  <= wordDone ? '0 : bitCnt_reg + 1'b1;
				end
				default: bitCnt_reg <= bitCnt_reg;
			endcase
		end
	end

	// ==========================================================
	// Received words buffered for the user side
	stream_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk      (sys_clk),
		.rst_n    (rst_n),
		.inData   ({tdiS, drShift_reg[WORD_W-1:1]}),
		.inValid  (wordDone),
		.inReady  (fifoInReady),
		.outData  (streamData),
		.outValid (streamValid),
		.outReady (streamTake)
	);

	// Host must stop shifting while this is low; a word taken then is lost
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			streamReady <= 1'b0;
		end else begin
			streamReady <= fifoInReady;
		end
	end

	// ==========================================================
	// Serial output
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tdoOut  <= 1'b0;
			tdoOe_n <= 1'b1;
		// [R4] Released whenever test reset is low
		end else if (!trstS_n) begin
			tdoOe_n <= 1'b1;
		// [R5] Update on falling edge
		end else if (tckFall) begin
			// [R4] Driven only while shifting
			tdoOe_n <= !(state_reg == SHIR || state_reg == SHDR);
			if (state_reg == SHIR) begin
				tdoOut <= irShift_reg[0];
			end else if (ir_reg == INSN_STREAM) begin
				tdoOut <= drShift_reg[0];
			end else begin
				tdoOut <= bypass_reg;
			end
		end
	end

	// ==========================================================
	// Debug event pulse on the shared pin
	logic [$clog2(DBG_PULSE_CYCLES+1)-1:0] pulseCnt_reg;
	// [R7] Low pulse per debug event
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pulseCnt_reg    <= '0;
			debugEventOut_n <= 1'b1;
			debugPinOe_n    <= 1'b1;
		end else begin
			debugPinOe_n <= !debugOutEnable;
			if (debugOutEnable && debugEvent) begin
				pulseCnt_reg    <= ($clog2(DBG_PULSE_CYCLES+1))'(DBG_PULSE_CYCLES);
				debugEventOut_n <= 1'b0;
			end else if (pulseCnt_reg > 1) begin
				pulseCnt_reg    <= pulseCnt_reg - 1'b1;
			end else begin
				pulseCnt_reg    <= '0;
				debugEventOut_n <= 1'b1;
			end
		end
	end
endmodule : test_access_debug_port

// *** tb/tap_port_asserts.sv ***
/* Checker for the test port: controller steps, output timing, event pulse.
   Sees top ports only; host test clock period of eight system clocks. */
`timescale 1ns/1ns
module tap_port_asserts (
	input wire logic                     sys_clk,
	input wire logic                     rst_n,
	input wire tap_port_pkg::jtag_pins_t pins,
	input wire logic                     tdoOut,
	input wire logic                     tdoOe_n,
	input wire logic                     debugEventOut_n,
	input wire logic                     debugPinOe_n,
	input wire logic                     debugOutEnable,
	input wire logic                     debugEvent,
	input wire logic [3:0]               tapState
);
	import tap_port_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Controller
	// exit from reset state
	property p_tlrExit;
		$changed(tapState) && $past(tapState) == TLR |->
			tapState == RTI && !$past(pins.tms, 2);
	endproperty
	a_tlrExit: assert property (p_tlrExit)
		else $error("wrong step out of reset state");
	property p_shirExit;
		$changed(tapState) && $past(tapState) == SHIR && pins.trstIn |->
			tapState == EX1IR && $past(pins.tms, 2);
	endproperty
	a_shirExit: assert property (p_shirExit)
		else $error("wrong step out of IR shift");
	property p_trst;
		(!pins.trstIn && debugPinOe_n) [*3] |->
			##[0:4] (tapState == TLR && tdoOe_n);
	endproperty
	a_trst: assert property (p_trst)
		else $error("test reset not honoured");
	property p_noTrst;
		(!debugPinOe_n && !pins.trstIn) [*4] |->
			tapState != TLR || $past(tapState) inside {TLR, SELIR};
	endproperty
	a_noTrst: assert property (p_noTrst)
		else $error("controller reset through event pin");
	// ==========================================================
	// Serial output
	// enable only in shift
	property p_oeFell;
		$fell(tdoOe_n) |-> tapState == SHIR || tapState == SHDR;
	endproperty
	a_oeFell: assert property (p_oeFell)
		else $error("output enabled outside shift");
	property p_oeRose;
		$rose(tdoOe_n) |=> tapState != SHIR && tapState != SHDR;
	endproperty
	a_oeRose: assert property (p_oeRose)
		else $error("output released inside shift");
	property p_tdoFall;
		$changed(tdoOut) || $changed(tdoOe_n) |-> !$past(pins.tck, 3);
	endproperty
	a_tdoFall: assert property (p_tdoFall)
		else $error("output changed after rising edge");
	// ==========================================================
	// Debug event
	// two cycle low pulse
	property p_dbgPulse;
		debugEvent && debugOutEnable |=>
			(!debugEventOut_n && !debugPinOe_n) [*2] ##1 debugEventOut_n;
	endproperty
	a_dbgPulse: assert property (p_dbgPulse)
		else $error("event pulse wrong");
	property p_dbgCause;
		$fell(debugEventOut_n) |-> $past(debugEvent && debugOutEnable);
	endproperty
	a_dbgCause: assert property (p_dbgCause)
		else $error("event pulse without cause");
endmodule : tap_port_asserts

bind test_access_debug_port tap_port_asserts u_chk (.sys_clk, .rst_n,
	.pins, .tdoOut, .tdoOe_n, .debugEventOut_n, .debugPinOe_n,
	.debugOutEnable, .debugEvent, .tapState);

// *** tb/jtag_host_model.sv ***
/* Host model: test clock, mode select, data and shared reset pin.
   Assumes the system clock; host edges are placed on its rising edges. */
`timescale 1ns/1ns
module jtag_host_model (
	input  wire logic                sys_clk,
	input  wire logic                tdoOut,
	input  wire logic                tdoOe_n,
	input  wire logic                debugEventOut_n,
	input  wire logic                debugPinOe_n,
	output tap_port_pkg::jtag_pins_t pins
);
	logic tck = 1'b0;
	logic tms = 1'b1;
	logic tdi = 1'b1;
	logic trstDrv = 1'b0;
	logic lastTdo = 1'b0;
	logic tdoWire;
	// Shared pin is wired low by either party
	assign pins = {tck, tms, tdi, trstDrv & (debugPinOe_n | debugEventOut_n)};
	// Released output shows the inverse of its last level
	assign tdoWire = tdoOe_n ? ~lastTdo : tdoOut;
	always @(posedge sys_clk) if (!tdoOe_n) lastTdo <= tdoOut;
	// One test clock period; sample at the rise
	task automatic tick(input logic m, input logic d, output logic q);
		@(posedge sys_clk);
		tms <= m;
		tdi <= d;
		repeat (3) @(posedge sys_clk);
		tck <= 1'b1;
		@(posedge sys_clk);
		q = tdoWire;
		repeat (3) @(posedge sys_clk);
		tck <= 1'b0;
	endtask : tick
	task automatic setTrst(input logic v);
		@(posedge sys_clk);
		trstDrv <= v;
	endtask : setTrst
endmodule : jtag_host_model

// *** tb/tb.sv ***
/* Testbench: IR load, stream words into the FIFO, test reset, events.
   Assumes the host model on the pins and a 20 MHz system clock. */
`timescale 1ns/1ns
module tb;
	import tap_port_pkg::*;
	logic       sys_clk, rst_n, tdoOut, tdoOe_n, debugEventOut_n;
	logic       debugPinOe_n, debugOutEnable, debugEvent, streamValid;
	logic       streamTake, streamReady;
	jtag_pins_t pins;
	logic [3:0] tapState;
	logic [7:0] streamData;
	int         miscompares = 0;
	int         n_checks = 0;
	test_access_debug_port DUT (.sys_clk, .rst_n, .pins, .tdoOut, .tdoOe_n,
		.debugEventOut_n, .debugPinOe_n, .debugOutEnable, .debugEvent,
		.tapState, .streamData, .streamValid, .streamTake, .streamReady);
	jtag_host_model host (.sys_clk, .tdoOut, .tdoOe_n, .debugEventOut_n,
		.debugPinOe_n, .pins);
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic walk(input logic [7:0] s, input int n);
		logic q;
		for (int i = 0; i < n; i++) host.tick(s[i], 1'b1, q);
		repeat (5) @(posedge sys_clk);
	endtask : walk
	task automatic shift(input logic [7:0] v, input int n,
			output logic [7:0] o);
		logic q;
		o = 8'h00;
		for (int i = 0; i < n; i++) begin
			host.tick(i == n - 1, v[i], q);
			o[i] = q;
		end
	endtask : shift
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish
	task automatic test_ir;
		logic [7:0] o;
		walk(8'h06, 5);
		chk(8'(tapState), 8'(SHIR));
		chk(8'(tdoOe_n), 8'h00);
		shift(8'(INSN_STREAM), 4, o);
		chk(o, 8'(IR_CAPTURE));
		walk(8'h01, 1);
		chk(8'(tapState), 8'(UPIR));
		$display("test_ir done");
	endtask : test_ir
	task automatic test_fifo;
		logic [7:0] o;
		for (int w = 0; w <= FIFO_DEPTH; w++) begin
			walk(8'h01, 3);
			shift(8'h3C + 8'(w), 8, o);
			chk(o, 8'h00);
			walk(8'h01, 1);
		end
		chk(8'(streamReady), 8'h00);
		for (int w = 0; w < FIFO_DEPTH; w++) begin
			@(posedge sys_clk);
			chk(streamData, 8'h3C + 8'(w));
			streamTake <= 1'b1;
			@(posedge sys_clk);
			streamTake <= 1'b0;
		end
		@(posedge sys_clk);
		chk(8'(streamValid), 8'h00);
		chk(8'(streamReady), 8'h01);
		$display("test_fifo done");
	endtask : test_fifo
	task automatic test_trst;
		walk(8'h01, 3);
		chk(8'(tdoOe_n), 8'h00);
		host.setTrst(1'b0);
		repeat (6) @(posedge sys_clk);
		chk(8'(tapState), 8'(TLR));
		chk(8'(tdoOe_n), 8'h01);
		host.setTrst(1'b1);
		$display("test_trst done");
	endtask : test_trst
	task automatic test_dbg;
		walk(8'h00, 1);
		debugOutEnable <= 1'b1;
		host.setTrst(1'b0);
		repeat (8) @(posedge sys_clk);
		chk(8'(tapState), 8'(RTI));
		chk(8'(debugPinOe_n), 8'h00);
		debugEvent <= 1'b1;
		@(posedge sys_clk);
		debugEvent <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			@(posedge sys_clk);
			chk(8'(debugEventOut_n), 8'(i == 2));
		end
		host.setTrst(1'b1);
		debugOutEnable <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk(8'(tapState), 8'(RTI));
		$display("test_dbg done");
	endtask : test_dbg
	task automatic test_rst;
		logic [7:0] o;
		@(posedge sys_clk);
		// System reset alone, test reset left high
		rst_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge sys_clk);
		chk(8'(tapState), 8'(TLR));
		chk(8'(tdoOe_n), 8'h01);
		walk(8'h02, 4);
		shift(8'hA5, 8, o);
		chk(o, 8'h4A);
		chk(8'(streamValid), 8'h00);
		$display("test_rst done");
	endtask : test_rst
	initial begin
		#200000;
		miscompares++;
		tally_and_finish;
	end
	initial begin
		// test reset held with system reset
		rst_n = 1'b0;
		debugOutEnable = 1'b0;
		debugEvent = 1'b0;
		streamTake = 1'b0;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		host.setTrst(1'b1);
		repeat (5) @(posedge sys_clk);
		chk(8'(tapState), 8'(TLR));
		chk(8'(tdoOe_n), 8'h01);
		chk(8'(streamReady), 8'h01);
		test_ir;
		test_fifo;
		test_trst;
		test_dbg;
		test_rst;
		tally_and_finish;
	end
endmodule : tb
